// ==== common/ctl_pkg.sv ====
// constants for the serial control port and its configuration bank
package ctl_pkg;
  // link constants
  localparam logic [6:0] DEV_ADDR_LO = 7'h40;
  localparam logic [6:0] DEV_ADDR_HI = 7'h41;
  localparam logic DIR_WRITE = 1'h0;
  localparam logic DIR_READ = 1'h1;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // register map
  localparam int NUM_REGS = 16;
  localparam logic [7:0] OFS_CLOCK_SOURCE_SELECT = 8'h01;
  localparam logic [7:0] OFS_POWER_CONTROL = 8'h02;
  localparam logic [7:0] OFS_AMPLIFIER_GAIN = 8'h07;
  localparam logic [7:0] OFS_SYNTH_MULTIPLIER_PREDIVIDE = 8'h08;
  localparam logic [7:0] OFS_SYNTH_FRACTION_HIGH_BYPASS = 8'h09;
  localparam logic [7:0] OFS_SYNTH_FRACTION_LOW = 8'h0a;
  localparam logic [7:0] REG_RESET = 8'h00;
  // field positions
  localparam int POS_SRC_LO = 4;
  localparam int POS_SYNTH_EN = 3;
  localparam int POS_P = 7;
  localparam int POS_BYPASS = 7;
  localparam int POS_AMP_DIGITAL = 5;
  localparam logic [5:0] GAIN_OFFSET_DB = 6'h07;
  // reference source codes
  localparam logic [1:0] SRC_MCLK = 2'h0;
  localparam logic [1:0] SRC_BCLK = 2'h1;
  localparam logic [1:0] SRC_SENSE = 2'h2;
  localparam logic [1:0] SRC_OSC = 2'h3;
endpackage : ctl_pkg

// ==== verif/bus_master_model.sv ====
// behavioural bus master that drives the serial control link
`timescale 1ns/100ps
module bus_master_model (
  input wire logic clk_sys,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  // idle bus: clock high, data released to the pull-up
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end

  // every change lands one step after a clock edge
  task automatic wait_clks(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wait_clks

  // also serves as repeated start: release data while clock is low first
  task automatic start_cond();
    sda_low = 1'h0;
    wait_clks(5);
    scl = 1'h1;
    wait_clks(10);
    sda_low = 1'h1;
    wait_clks(10);
    scl = 1'h0;
    wait_clks(6);
  endtask : start_cond

  // data rises while clock is high; line then floats high on the pull-up
  task automatic stop_cond();
    sda_low = 1'h1;
    wait_clks(5);
    scl = 1'h1;
    wait_clks(10);
    sda_low = 1'h0;
    wait_clks(10);
  endtask : stop_cond

  // one clock pulse; data set four clocks before the rise, late in the low phase, sampled mid-high
  task automatic bit_cycle(input logic b, output logic seen);
    sda_low = ~b;
    wait_clks(4);
    scl = 1'h1;
    wait_clks(5);
    seen = sda_line;
    wait_clks(5);
    scl = 1'h0;
    wait_clks(6);
  endtask : bit_cycle

  // send a byte msb first, then release for the acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], s);
    end
    bit_cycle(1'h1, s);
    ack = ~s;
  endtask : wr_byte

  // receive a byte; acknowledge unless it is the last one
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'h1, d[i]);
    end
    bit_cycle(last, s);
  endtask : rd_byte
endmodule : bus_master_model

// ==== verif/ctl_port_tb.sv ====
// self-checking bench for the serial control port
`timescale 1ns/100ps
`define CHK(what, exp, got) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("CHECK FAILED %s exp %h got %h", what, exp, got); \
  end \
end
module ctl_port_tb;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic addr_sel = 1'h0;
  logic scl, sda_low, sda_out, sda_oe, sda_line;
  logic synth_enable, synth_bypass, synth_p, amp_src_digital;
  logic [3:0] synth_ref_clock_sel;
  logic [6:0] synth_j;
  logic [13:0] synth_d;
  logic [4:0] amp_gain_code;
  logic signed [5:0] amp_gain_db;
  logic [4:0] codes [4] = '{5'h00, 5'h01, 5'h07, 5'h1f};
  logic [7:0] zq[$];
  int n_errors = 0;
  int checks_done = 0;

  always #25 clk_sys = ~clk_sys;
  // open-drain data line with pull-up
  assign sda_line = ~(sda_low | (sda_oe & ~sda_out));

  bus_master_model bus_master_model_i (
    .clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_low(sda_low)
  );
  ctl_port ctl_port_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel),
    .synth_enable(synth_enable), .synth_bypass(synth_bypass),
    .synth_ref_clock_sel(synth_ref_clock_sel), .synth_j(synth_j),
    .synth_d(synth_d), .synth_p(synth_p), .amp_gain_code(amp_gain_code),
    .amp_gain_db(amp_gain_db), .amp_src_digital(amp_src_digital)
  );

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  // register write burst; a foreign address stops after the nack
  task automatic wr_seq(input logic [6:0] dev, input logic [7:0] ptr,
                        input logic [7:0] q[$], input logic exp_ack);
    logic ack;
    bus_master_model_i.start_cond();
    bus_master_model_i.wr_byte({dev, ctl_pkg::DIR_WRITE}, ack);
    `CHK("address ack", exp_ack, ack)
    if (ack === 1'h1) begin
      bus_master_model_i.wr_byte(ptr, ack);
      `CHK("pointer ack", 1'h1, ack)
      foreach (q[i]) begin
        bus_master_model_i.wr_byte(q[i], ack);
        `CHK("data ack", 1'h1, ack)
      end
    end
    bus_master_model_i.stop_cond();
  endtask : wr_seq

  // pointer write, repeated start, then a read burst
  task automatic rd_seq(input logic [6:0] dev, input logic [7:0] ptr,
                        input logic [7:0] exp[$]);
    logic ack;
    logic [7:0] d;
    bus_master_model_i.start_cond();
    bus_master_model_i.wr_byte({dev, ctl_pkg::DIR_WRITE}, ack);
    `CHK("read address ack", 1'h1, ack)
    bus_master_model_i.wr_byte(ptr, ack);
    `CHK("read pointer ack", 1'h1, ack)
    bus_master_model_i.start_cond();
    bus_master_model_i.wr_byte({dev, ctl_pkg::DIR_READ}, ack);
    `CHK("read select ack", 1'h1, ack)
    foreach (exp[i]) begin
      bus_master_model_i.rd_byte(i == exp.size() - 1, d);
      `CHK("read data", exp[i], d)
    end
    bus_master_model_i.stop_cond();
    `CHK("line released", 1'h0, sda_oe)
  endtask : rd_seq

  // watchdog cuts a hang short
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_errors++;
    end_sim();
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    #1 rst_n = 1'h1;
    repeat (5) @(posedge clk_sys);
    #1;
    // registers 0x00 to 0x0a read back zero after reset
    `CHK("j reset", 7'h00, synth_j)
    `CHK("p reset", 1'h0, synth_p)
    `CHK("d reset", 14'h0000, synth_d)
    repeat (11) zq.push_back(8'h00);
    rd_seq(ctl_pkg::DEV_ADDR_LO, 8'h00, zq);
    // j=7, d=6716, p=1 keeps a ~11.77 MHz reference in range
    wr_seq(ctl_pkg::DEV_ADDR_LO, ctl_pkg::OFS_SYNTH_MULTIPLIER_PREDIVIDE,
           '{8'h87, 8'h9a, 8'h3c}, 1'h1);
    `CHK("j field", 7'h07, synth_j)
    `CHK("p field", 1'h1, synth_p)
    `CHK("bypass", 1'h1, synth_bypass)
    `CHK("d field", 14'h1a3c, synth_d)
    rd_seq(ctl_pkg::DEV_ADDR_LO, 8'h08, '{8'h87, 8'h9a, 8'h3c});
    // every reference source code
    for (int c = 0; c < 4; c++) begin
      wr_seq(ctl_pkg::DEV_ADDR_LO, ctl_pkg::OFS_CLOCK_SOURCE_SELECT,
             '{8'(c << 4)}, 1'h1);
      `CHK("ref select", 4'h1 << c, synth_ref_clock_sel)
    end
    // synthesizer enable set then cleared
    for (int e = 1; e >= 0; e--) begin
      wr_seq(ctl_pkg::DEV_ADDR_LO, ctl_pkg::OFS_POWER_CONTROL,
             '{8'(e << 3)}, 1'h1);
      `CHK("synth enable", 1'(e), synth_enable)
    end
    // gain table ends and steps, alternating input source
    for (int k = 0; k < 4; k++) begin
      wr_seq(ctl_pkg::DEV_ADDR_LO, ctl_pkg::OFS_AMPLIFIER_GAIN,
             '{{2'h0, 1'(k % 2), codes[k]}}, 1'h1);
      `CHK("gain code", codes[k], amp_gain_code)
      `CHK("gain db", 6'(codes[k]) - ctl_pkg::GAIN_OFFSET_DB,
           amp_gain_db)
      `CHK("source", 1'(k % 2), amp_src_digital)
    end
    // fraction cleared: integer-only setting, reference over two stays legal
    wr_seq(ctl_pkg::DEV_ADDR_LO, ctl_pkg::OFS_SYNTH_FRACTION_HIGH_BYPASS,
           '{8'h00, 8'h00}, 1'h1);
    `CHK("d cleared", 14'h0000, synth_d)
    `CHK("bypass off", 1'h0, synth_bypass)
    // foreign address is ignored
    wr_seq(ctl_pkg::DEV_ADDR_HI, ctl_pkg::OFS_AMPLIFIER_GAIN,
           '{8'h05}, 1'h0);
    `CHK("gain kept", 5'h1f, amp_gain_code)
    // alternate address select
    @(posedge clk_sys);
    #1 addr_sel = 1'h1;
    repeat (5) @(posedge clk_sys);
    wr_seq(ctl_pkg::DEV_ADDR_LO, ctl_pkg::OFS_AMPLIFIER_GAIN,
           '{8'h02}, 1'h0);
    wr_seq(ctl_pkg::DEV_ADDR_HI, ctl_pkg::OFS_AMPLIFIER_GAIN,
           '{8'h0c}, 1'h1);
    `CHK("gain code hi", 5'h0c, amp_gain_code)
    `CHK("gain db hi", 6'sh05, amp_gain_db)
    rd_seq(ctl_pkg::DEV_ADDR_HI, 8'h07, '{8'h0c});
    // past the bank: write dropped, read returns zero
    wr_seq(ctl_pkg::DEV_ADDR_HI, 8'h10, '{8'haa}, 1'h1);
    rd_seq(ctl_pkg::DEV_ADDR_HI, 8'h0f, '{8'h00, 8'h00});
    end_sim();
  end
endmodule : ctl_port_tb

// ==== verilog/cfg_bank.sv ====
// configuration register bank with decoded synthesizer and gain fields
`timescale 1ns/100ps
module cfg_bank (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  output logic synth_enable,
  output logic synth_bypass,
  output logic [3:0] synth_ref_clock_sel,
  output logic [6:0] synth_j,
  output logic [13:0] synth_d,
  output logic synth_p,
  output logic [4:0] amp_gain_code,
  output logic signed [5:0] amp_gain_db,
  output logic amp_src_digital
);
  logic [7:0] mem_r [ctl_pkg::NUM_REGS];
  logic [3:0] ref_sel_r;
  logic signed [5:0] gain_db_r;
  logic [1:0] src_code;

  // storage; addresses past the bank are dropped on write, read as zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < ctl_pkg::NUM_REGS; i++) begin
        mem_r[i] <= ctl_pkg::REG_RESET;
      end
    end else if (wr_en && wr_addr < 8'(ctl_pkg::NUM_REGS)) begin
      mem_r[wr_addr[3:0]] <= wr_data;
    end
  end

  assign rd_data = (rd_addr < 8'(ctl_pkg::NUM_REGS)) ?
                   mem_r[rd_addr[3:0]] : 8'h00;

  assign src_code = mem_r[ctl_pkg::OFS_CLOCK_SOURCE_SELECT[3:0]]
                    [ctl_pkg::POS_SRC_LO +: 2];

  // one-hot reference select: mclk, bit clock, sense clock, oscillator
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ref
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) ref_sel_r[g] <= 1'h0;
        else ref_sel_r[g] <= (src_code == 2'(g));
      end
    end
  endgenerate

  // gain in dB kept registered so the amplifier sees a settled value
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) gain_db_r <= 6'sh00;
    else gain_db_r <= $signed({1'h0,
      mem_r[ctl_pkg::OFS_AMPLIFIER_GAIN[3:0]][4:0]})
      - $signed(ctl_pkg::GAIN_OFFSET_DB);
  end

  assign synth_ref_clock_sel = ref_sel_r;
  assign amp_gain_db = gain_db_r;
  assign synth_enable = mem_r[ctl_pkg::OFS_POWER_CONTROL[3:0]]
                        [ctl_pkg::POS_SYNTH_EN];
  assign synth_bypass = mem_r[ctl_pkg::OFS_SYNTH_FRACTION_HIGH_BYPASS[3:0]]
                        [ctl_pkg::POS_BYPASS];
  assign synth_j = mem_r[ctl_pkg::OFS_SYNTH_MULTIPLIER_PREDIVIDE[3:0]][6:0];
  assign synth_p = mem_r[ctl_pkg::OFS_SYNTH_MULTIPLIER_PREDIVIDE[3:0]]
                   [ctl_pkg::POS_P];
  // fraction joins the high six bits and the low byte
  assign synth_d = {mem_r[ctl_pkg::OFS_SYNTH_FRACTION_HIGH_BYPASS[3:0]][5:0],
                    mem_r[ctl_pkg::OFS_SYNTH_FRACTION_LOW[3:0]]};
  assign amp_gain_code = mem_r[ctl_pkg::OFS_AMPLIFIER_GAIN[3:0]][4:0];
  // a single select bit: exactly one source, never a sum
  assign amp_src_digital = mem_r[ctl_pkg::OFS_AMPLIFIER_GAIN[3:0]]
                           [ctl_pkg::POS_AMP_DIGITAL];

  property p_enable_follows_write;
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_en && wr_addr == ctl_pkg::OFS_POWER_CONTROL)
      |=> synth_enable == $past(wr_data[3]);
  endproperty
  a_enable_follows_write: assert property (p_enable_follows_write)
    else $error("synth enable does not follow power write");

  property p_osc_select;
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_en && wr_addr == ctl_pkg::OFS_CLOCK_SOURCE_SELECT
     && wr_data[5:4] == ctl_pkg::SRC_OSC) |-> ##2 synth_ref_clock_sel == 4'h8;
  endproperty
  a_osc_select: assert property (p_osc_select)
    else $error("oscillator not selected as reference");
endmodule : cfg_bank

// ==== verilog/ctl_port.sv ====
// serial control slave with auto-incrementing register access
`timescale 1ns/100ps
module ctl_port (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_sel,
  output logic synth_enable,
  output logic synth_bypass,
  output logic [3:0] synth_ref_clock_sel,
  output logic [6:0] synth_j,
  output logic [13:0] synth_d,
  output logic synth_p,
  output logic [4:0] amp_gain_code,
  output logic signed [5:0] amp_gain_db,
  output logic amp_src_digital
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_WR, ST_RD, ST_RACK, ST_IGNORE
  } port_state_t;

  port_state_t state_r;
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic [1:0] sel_sync_r;
  logic scl_d_r;
  logic sda_d_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic [7:0] ptr_r;
  logic rw_r;
  logic got_reg_r;
  logic nack_r;
  logic oe_r;
  logic out_r;
  logic wr_en_r;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic [7:0] rd_data;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic byte_done;
  logic [6:0] own_addr;

  // two-stage synchronisers on the pins; stage one feeds stage two only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      sel_sync_r <= 2'h0;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      sel_sync_r <= {sel_sync_r[0], addr_sel};
    end
  end

  assign scl_s = scl_sync_r[1];
  assign sda_s = sda_sync_r[1];

  // delayed copies for edge detection, taken from the settled stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_r <= 1'h1;
      sda_d_r <= 1'h1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  // sda moving while scl high marks start or stop
  assign start_det = scl_s && scl_d_r && !sda_s && sda_d_r;
  assign stop_det = scl_s && scl_d_r && sda_s && !sda_d_r;
  assign byte_done = scl_fall && cnt_r == ctl_pkg::BITS_PER_BYTE;
  // address pin is a strap but sampled live so it may be rewired
  assign own_addr = sel_sync_r[1] ? ctl_pkg::DEV_ADDR_HI :
                    ctl_pkg::DEV_ADDR_LO;

  // bit counter: data rises only; counting the acknowledge clock would
  // close the following byte one bit early
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) cnt_r <= 4'h0;
    else if (start_det || stop_det) cnt_r <= 4'h0;
    else if (scl_fall && cnt_r == ctl_pkg::BITS_PER_BYTE) cnt_r <= 4'h0;
    else if (scl_rise && state_r != ST_ACK && state_r != ST_RACK) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // receive shifter, msb arrives first
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) shift_r <= 8'h00;
    else if (scl_rise) shift_r <= {shift_r[6:0], sda_s};
  end

  // master answer to each read byte: high means not-acknowledge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) nack_r <= 1'h0;
    else if (state_r == ST_RACK && scl_rise) nack_r <= sda_s;
  end

  // main sequencer; start wins over every state, stop returns to idle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      rw_r <= ctl_pkg::DIR_WRITE;
      got_reg_r <= 1'h0;
    end else if (start_det) begin
      state_r <= ST_ADDR;
      got_reg_r <= 1'h0;
    end else if (stop_det) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: state_r <= ST_IDLE;
        ST_ADDR: begin
          if (byte_done) begin
            if (shift_r[7:1] == own_addr) begin
              state_r <= ST_ACK;
              rw_r <= shift_r[0];
            end else begin
              state_r <= ST_IGNORE;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            state_r <= (rw_r == ctl_pkg::DIR_READ) ? ST_RD : ST_WR;
          end
        end
        ST_WR: begin
          if (byte_done) begin
            state_r <= ST_ACK;
            got_reg_r <= 1'h1;
          end
        end
        ST_RD: if (byte_done) state_r <= ST_RACK;
        ST_RACK: begin
          if (scl_fall) state_r <= nack_r ? ST_IGNORE : ST_RD;
        end
        ST_IGNORE: state_r <= ST_IGNORE;
      endcase
    end
  end

  // register pointer and transmit byte; pointer loads from the first written byte, then steps once per data byte
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ptr_r <= 8'h00;
      tx_r <= 8'h00;
    end else if (!start_det && !stop_det) begin
      if (state_r == ST_WR && byte_done) begin
        ptr_r <= got_reg_r ? ptr_r + 8'h01 : shift_r;
      end else if (scl_fall && ((state_r == ST_ACK && rw_r)
                 || (state_r == ST_RACK && !nack_r))) begin
        tx_r <= rd_data;
        ptr_r <= ptr_r + 8'h01;
      end else if (state_r == ST_RD && scl_fall) begin
        tx_r <= {tx_r[6:0], 1'h0};
      end
    end
  end

  // data writes land one cycle after the data byte completes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_en_r <= 1'h0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
    end else begin
      wr_en_r <= state_r == ST_WR && byte_done && got_reg_r
                 && !start_det && !stop_det;
      wr_addr_r <= ptr_r;
      wr_data_r <= shift_r;
    end
  end

  // data line drive; changes only after scl falls, so it settles while
  // scl is low; the synchroniser lag is far below the low period
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      oe_r <= 1'h0;
    end else if (start_det || stop_det) begin
      oe_r <= 1'h0;
    end else if (scl_fall) begin
      unique case (state_r)
        ST_ADDR: oe_r <= byte_done && shift_r[7:1] == own_addr;
        ST_WR: oe_r <= byte_done;
        ST_ACK: oe_r <= rw_r && !rd_data[7];
        ST_RD: oe_r <= byte_done ? 1'h0 : !tx_r[6];
        ST_RACK: oe_r <= !nack_r && !rd_data[7];
        default: oe_r <= 1'h0;
      endcase
    end
  end

  // open-drain: the driven level is always low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) out_r <= 1'h0;
    else out_r <= 1'h0;
  end

  assign sda_oe = oe_r;
  assign sda_out = out_r;

  cfg_bank u_bank (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(wr_en_r),
    .wr_addr(wr_addr_r),
    .wr_data(wr_data_r),
    .rd_addr(ptr_r),
    .rd_data(rd_data),
    .synth_enable(synth_enable),
    .synth_bypass(synth_bypass),
    .synth_ref_clock_sel(synth_ref_clock_sel),
    .synth_j(synth_j),
    .synth_d(synth_d),
    .synth_p(synth_p),
    .amp_gain_code(amp_gain_code),
    .amp_gain_db(amp_gain_db),
    .amp_src_digital(amp_src_digital)
  );

  property p_ack_own_addr;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_ADDR && byte_done && !start_det && !stop_det
     && shift_r[7:1] == own_addr) |=> sda_oe && state_r == ST_ACK;
  endproperty
  a_ack_own_addr: assert property (p_ack_own_addr)
    else $error("own address not acknowledged");

  property p_low_read_addr;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_ADDR && byte_done && !start_det && !stop_det
     && shift_r == 8'h81 && !sel_sync_r[1]) |=> rw_r && sda_oe;
  endproperty
  a_low_read_addr: assert property (p_low_read_addr)
    else $error("read byte 0x81 not taken with select low");

  property p_high_write_addr;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_ADDR && byte_done && !start_det && !stop_det
     && shift_r == 8'h82 && sel_sync_r[1]) |=> !rw_r && sda_oe;
  endproperty
  a_high_write_addr: assert property (p_high_write_addr)
    else $error("write byte 0x82 not taken with select high");

  property p_ignore_other;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_ADDR && byte_done && !start_det && !stop_det
     && shift_r[7:1] != own_addr) |=> !sda_oe [*2];
  endproperty
  a_ignore_other: assert property (p_ignore_other)
    else $error("data line driven for foreign address");

  property p_ack_write_byte;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_WR && byte_done && !start_det && !stop_det)
      |=> sda_oe && state_r == ST_ACK;
  endproperty
  a_ack_write_byte: assert property (p_ack_write_byte)
    else $error("written byte not acknowledged");

  property p_stop_releases;
    @(posedge clk_sys) disable iff (!rst_n)
    stop_det && !start_det |=> state_r == ST_IDLE && !sda_oe;
  endproperty
  a_stop_releases: assert property (p_stop_releases)
    else $error("stop did not release the line");

  property p_first_bit_msb;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_ACK && rw_r && scl_fall && !start_det && !stop_det)
      |=> sda_oe == !$past(rd_data[7]) && tx_r == $past(rd_data);
  endproperty
  a_first_bit_msb: assert property (p_first_bit_msb)
    else $error("read byte msb not presented first");

  property p_nack_releases;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_RACK && scl_fall && nack_r && !start_det && !stop_det)
      |=> !sda_oe && state_r == ST_IGNORE;
  endproperty
  a_nack_releases: assert property (p_nack_releases)
    else $error("device kept sending after not-acknowledge");

  property p_ptr_advance;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_WR && byte_done && got_reg_r && !start_det && !stop_det)
      |=> ptr_r == 8'($past(ptr_r) + 8'h01) && wr_en_r
          && wr_addr_r == $past(ptr_r);
  endproperty
  a_ptr_advance: assert property (p_ptr_advance)
    else $error("pointer did not advance after data byte");
endmodule : ctl_port
